// ===== src/edr_debug_read.sv
// Debug read leaf of the enclave system instruction, with register port.
// Assumes the page map, segment unit and cache memory answer one lookup
// on clk_sys, holding lookup_ack high for one cycle with all answers.
//
// What this block does
// [RQ1] Runs the debug read when leaf code 04H is in the leaf register.
// [RQ2] Moves eight bytes in wide mode, four otherwise; width fixed.
// [RQ3] Wide mode flag is long mode active AND code segment long.
// [RQ4] Misaligned address (8 wide, 4 narrow) gives protection fault 0.
// [RQ5] Address outside protected page cache gives page fault on it.
// [RQ6] Concurrent modifier of the same map entry gives protection fault.
// [RQ7] Map entry valid bit clear gives page fault.
// [RQ8] Page fault unless type regular, thread, version, shadow stack.
// [RQ9] Pending or modified: zero flag set, not-debuggable code, no read.
// [RQ10] Thread page offset at or above size limit gives protection fault.
// [RQ11] Regular or thread page of non-debug enclave gives protection fault.
// [RQ12] Regular or thread page: copy 64 bits wide, 32 bits to low half.
// [RQ13] Version page: mask low three bits, return all ones or zero.
// [RQ14] Success writes zero status and clears the zero flag.
// [RQ15] Success and not-debuggable clear carry, parity, aux, overflow, sign.
// [RQ16] Page read, write, execute permissions are ignored.
// [RQ17] Wide mode non-canonical address gives protection fault.
// [RQ18] Unusable data segment or limit violation gives protection fault.
// [RQ19] Checks run in fixed order; first failure wins; faults keep data.
`timescale 1ns/100ps
module edr_debug_read #(
   parameter int VA_BITS = 48,
   parameter logic [11:0] TCS_LIMIT = 12'h100,
   parameter logic [31:0] NOT_DEBUGGABLE_CODE = 32'h0000_0001
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata,
   // Page map lookup
   output logic lookup_req,
   output logic [63:0] lookup_addr,
   input wire logic lookup_ack,
   input wire logic seg_fault,
   input wire logic in_cache,
   input wire logic entry_conflict,
   input wire logic entry_valid,
   input wire logic [7:0] entry_type,
   input wire logic entry_pending,
   input wire logic entry_modified,
   input wire logic owner_debug,
   input wire logic [63:0] mem_data,
   // Fault reporting and event interrupt
   output logic gp_fault,
   output logic page_fault,
   output logic [63:0] fault_addr,
   output logic irq
);

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      edr_pkg::edr_state_t state;
      logic [31:0] leaf;
      logic [63:0] addr;
      logic lma;
      logic csl;
      logic [63:0] data;
      logic [31:0] status;
      logic [5:0] flags;
      logic gp;
      logic pf;
      logic [63:0] faddr;
      logic [edr_pkg::IRQ_BITS-1:0] irq_stat;
      logic [edr_pkg::IRQ_BITS-1:0] irq_en;
      logic [31:0] rdata;
   } edr_regs_t;

   edr_regs_t s;
   edr_regs_t next_s;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction

   logic wide;
   logic start_wide;
   logic misaligned;
   logic canonical;
   logic type_ok;
   logic is_reg_tcs;
   logic start_req;
   logic [63:0] va_val;
   logic [edr_pkg::IRQ_BITS-1:0] ev;

   assign wide = s.lma & s.csl; // [RQ3]
   // The starting write carries the mode bits, so its own checks use them
   assign start_wide = reg_wdata[edr_pkg::CTRL_LMA]
                       & reg_wdata[edr_pkg::CTRL_CSL]; // [RQ3]
   // Alignment width follows the mode flag only, never an override
   assign misaligned = start_wide ? (s.addr[2:0] != 3'h0)
                                  : (s.addr[1:0] != 2'h0); // [RQ4]
   assign canonical = (&s.addr[63:VA_BITS-1])
                      | ~(|s.addr[63:VA_BITS-1]); // [RQ17]
   assign type_ok = entry_type == edr_pkg::regular_page_type
                    || entry_type == edr_pkg::thread_control_page_type
                    || entry_type == edr_pkg::version_array_page_type
                    || entry_type == edr_pkg::shadow_stack_first_type
                    || entry_type == edr_pkg::shadow_stack_rest_type; // [RQ8]
   assign is_reg_tcs = entry_type == edr_pkg::regular_page_type
                       || entry_type == edr_pkg::thread_control_page_type;
   assign va_val = mem_data & ~edr_pkg::VA_SLOT_MASK; // [RQ13]
   assign start_req = reg_write && hit(reg_addr, edr_pkg::REG_CTRL)
                      && reg_wdata[edr_pkg::CTRL_START]
                      && s.state == edr_pkg::ST_IDLE
                      && s.leaf == edr_pkg::LEAF_DEBUG_READ; // [RQ1]

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb begin
      next_s = s;
      ev = '0;
      next_s.gp = 1'b0;
      next_s.pf = 1'b0;
      // Operand registers are frozen while a lookup is outstanding
      if (reg_write && s.state == edr_pkg::ST_IDLE) begin
         if (hit(reg_addr, edr_pkg::REG_LEAF)) begin
            next_s.leaf = reg_wdata;
         end
         if (hit(reg_addr, edr_pkg::REG_ADDR_LO)) begin
            next_s.addr[31:0] = reg_wdata;
         end
         if (hit(reg_addr, edr_pkg::REG_ADDR_HI)) begin
            next_s.addr[63:32] = reg_wdata;
         end
         if (hit(reg_addr, edr_pkg::REG_CTRL)) begin
            next_s.lma = reg_wdata[edr_pkg::CTRL_LMA];
            next_s.csl = reg_wdata[edr_pkg::CTRL_CSL];
         end
      end
      if (reg_write && hit(reg_addr, edr_pkg::REG_IRQ_ENABLE)) begin
         next_s.irq_en = reg_wdata[edr_pkg::IRQ_BITS-1:0];
      end
      unique case (s.state)
         edr_pkg::ST_IDLE: begin
            if (start_req) begin
               // Address-only checks decide before any lookup
               if (start_wide && !canonical) begin
                  ev[edr_pkg::IRQ_GP] = 1'b1; // [RQ17]
               end else if (misaligned) begin
                  ev[edr_pkg::IRQ_GP] = 1'b1; // [RQ4] [RQ19]
               end else begin
                  next_s.state = edr_pkg::ST_LOOKUP;
               end
            end
         end
         edr_pkg::ST_LOOKUP: begin
            if (lookup_ack) begin
               next_s.state = edr_pkg::ST_IDLE;
               // Permission bits of the entry are not even an input
               if (seg_fault) begin
                  ev[edr_pkg::IRQ_GP] = 1'b1; // [RQ18] [RQ16]
               end else if (!in_cache) begin
                  ev[edr_pkg::IRQ_PF] = 1'b1; // [RQ5]
               end else if (entry_conflict) begin
                  ev[edr_pkg::IRQ_GP] = 1'b1; // [RQ6]
               end else if (!entry_valid) begin
                  ev[edr_pkg::IRQ_PF] = 1'b1; // [RQ7]
               end else if (!type_ok) begin
                  ev[edr_pkg::IRQ_PF] = 1'b1; // [RQ8]
               end else if (entry_pending || entry_modified) begin
                  ev[edr_pkg::IRQ_NDBG] = 1'b1; // [RQ9]
                  next_s.status = NOT_DEBUGGABLE_CODE;
                  next_s.flags = '0; // [RQ15]
                  next_s.flags[edr_pkg::FLAG_ZF] = 1'b1;
               end else if (entry_type == edr_pkg::thread_control_page_type
                  && (s.addr & edr_pkg::PAGE_OFFSET_MASK)
                     >= {52'h0, TCS_LIMIT}) begin
                  ev[edr_pkg::IRQ_GP] = 1'b1; // [RQ10]
               end else if (is_reg_tcs && !owner_debug) begin
                  ev[edr_pkg::IRQ_GP] = 1'b1; // [RQ11] [RQ19]
               end else begin
                  ev[edr_pkg::IRQ_DONE] = 1'b1;
                  if (is_reg_tcs) begin
                     if (wide) begin
                        next_s.data = mem_data; // [RQ12] [RQ2]
                     end else begin
                        next_s.data[31:0] = mem_data[31:0]; // [RQ12]
                     end
                  end else if (wide) begin
                     next_s.data = (va_val != '0) ? edr_pkg::ALL_ONES
                                                  : '0; // [RQ13]
                  end else begin
                     next_s.data[31:0] = (va_val != '0)
                        ? edr_pkg::ALL_ONES[31:0] : 32'h0000_0000; // [RQ13]
                  end
                  next_s.status = '0; // [RQ14]
                  next_s.flags = '0; // [RQ14] [RQ15]
               end
            end
         end
      endcase
      next_s.gp = ev[edr_pkg::IRQ_GP];
      next_s.pf = ev[edr_pkg::IRQ_PF];
      if (ev[edr_pkg::IRQ_GP] || ev[edr_pkg::IRQ_PF]) begin
         next_s.faddr = s.addr;
      end
      // A clear and a new event in one cycle leave the bit set
      if (reg_write && hit(reg_addr, edr_pkg::REG_IRQ_CLEAR)) begin
         next_s.irq_stat = s.irq_stat & ~reg_wdata[edr_pkg::IRQ_BITS-1:0];
      end
      next_s.irq_stat = next_s.irq_stat | ev;
      // Read data stands only in the cycle after the strobe
      next_s.rdata = '0;
      if (reg_read) begin
         unique case (1'b1)
            hit(reg_addr, edr_pkg::REG_LEAF): next_s.rdata = s.leaf;
            hit(reg_addr, edr_pkg::REG_ADDR_LO): next_s.rdata = s.addr[31:0];
            hit(reg_addr, edr_pkg::REG_ADDR_HI):
               next_s.rdata = s.addr[63:32];
            hit(reg_addr, edr_pkg::REG_CTRL): begin
               next_s.rdata[edr_pkg::CTRL_LMA] = s.lma;
               next_s.rdata[edr_pkg::CTRL_CSL] = s.csl;
            end
            hit(reg_addr, edr_pkg::REG_DATA_LO): next_s.rdata = s.data[31:0];
            hit(reg_addr, edr_pkg::REG_DATA_HI):
               next_s.rdata = s.data[63:32];
            hit(reg_addr, edr_pkg::REG_STATUS): next_s.rdata = s.status;
            hit(reg_addr, edr_pkg::REG_FLAGS): begin
               next_s.rdata[5:0] = s.flags;
               next_s.rdata[edr_pkg::FLAG_BUSY] =
                  s.state == edr_pkg::ST_LOOKUP;
               next_s.rdata[edr_pkg::FLAG_GP] = s.irq_stat[edr_pkg::IRQ_GP];
               next_s.rdata[edr_pkg::FLAG_PFLT] =
                  s.irq_stat[edr_pkg::IRQ_PF];
            end
            hit(reg_addr, edr_pkg::REG_IRQ_STATUS):
               next_s.rdata[edr_pkg::IRQ_BITS-1:0] = s.irq_stat;
            hit(reg_addr, edr_pkg::REG_IRQ_ENABLE):
               next_s.rdata[edr_pkg::IRQ_BITS-1:0] = s.irq_en;
            default: next_s.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign reg_rdata = s.rdata;
   assign lookup_req = s.state == edr_pkg::ST_LOOKUP;
   assign lookup_addr = s.addr;
   assign gp_fault = s.gp;
   assign page_fault = s.pf;
   assign fault_addr = s.faddr;
   assign irq = |(s.irq_stat & s.irq_en);

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence ack_clean_s;
      lookup_ack && lookup_req && !seg_fault && in_cache
         && !entry_conflict && entry_valid && type_ok;
   endsequence

   sequence ack_ready_s;
      ack_clean_s ##0 (!entry_pending && !entry_modified
         && !(is_reg_tcs && !owner_debug)
         && entry_type != edr_pkg::thread_control_page_type);
   endsequence

   bad_leaf_idle_a: assert property ( // [RQ1]
      (reg_write && hit(reg_addr, edr_pkg::REG_CTRL)
         && reg_wdata[edr_pkg::CTRL_START]
         && s.leaf != edr_pkg::LEAF_DEBUG_READ && !lookup_req)
      |=> !lookup_req && !gp_fault)
      else $error("start with wrong leaf code was acted on");

   narrow_high_kept_a: assert property ( // [RQ2]
      (ack_ready_s ##0 !wide) |=> s.data[63:32] == $past(s.data[63:32]))
      else $error("narrow read changed the upper data half");

   wide_flag_a: assert property ( // [RQ3]
      (ack_ready_s ##0 (s.lma && s.csl && entry_type
         == edr_pkg::regular_page_type))
      |=> s.data == $past(mem_data))
      else $error("wide read did not copy all 64 bits");

   align_fault_a: assert property ( // [RQ4]
      (start_req && misaligned) |=> gp_fault && !lookup_req
         ##1 !gp_fault)
      else $error("misaligned address did not fault for one cycle");

   residency_pf_a: assert property ( // [RQ5]
      (lookup_req && lookup_ack && !seg_fault && !in_cache)
      |=> page_fault && fault_addr == $past(s.addr))
      else $error("address outside cache did not page fault");

   conflict_gp_a: assert property ( // [RQ6]
      (lookup_req && lookup_ack && !seg_fault && in_cache
         && entry_conflict) |=> gp_fault && !page_fault)
      else $error("concurrent modifier did not protection fault");

   not_debug_a: assert property ( // [RQ9]
      (ack_clean_s ##0 (entry_pending || entry_modified))
      |=> s.flags[edr_pkg::FLAG_ZF] && s.status == NOT_DEBUGGABLE_CODE
         && s.data == $past(s.data) && s.flags[5:1] == 5'h00)
      else $error("pending page did not report not-debuggable");

   debug_attr_a: assert property ( // [RQ11]
      (ack_clean_s ##0 (!entry_pending && !entry_modified && is_reg_tcs
         && !owner_debug)) |=> gp_fault && s.data == $past(s.data))
      else $error("non-debug owner did not protection fault");

   version_mask_a: assert property ( // [RQ13]
      (ack_ready_s ##0 (entry_type == edr_pkg::version_array_page_type
         && wide)) |=> s.data == (($past(va_val) != '0)
            ? edr_pkg::ALL_ONES : 64'h0000_0000_0000_0000))
      else $error("version slot indicator wrong");

   success_status_a: assert property ( // [RQ14]
      ack_ready_s |=> s.status == 32'h0000_0000 && s.flags == 6'h00
         && !gp_fault && !page_fault)
      else $error("success did not clear status and flags");

endmodule

// ===== src/edr_pkg.sv
// Constants, register map and state types of the debug read leaf block.
// Assumes a 32-bit register port and a page map lookup on the same clock.
package edr_pkg;

   // -------------------------------------------------------------
   // Leaf code and page types
   // -------------------------------------------------------------
   localparam logic [31:0] LEAF_DEBUG_READ = 32'h0000_0004;
   localparam logic [7:0] regular_page_type = 8'h00;
   localparam logic [7:0] thread_control_page_type = 8'h01;
   localparam logic [7:0] version_array_page_type = 8'h02;
   localparam logic [7:0] shadow_stack_first_type = 8'h03;
   localparam logic [7:0] shadow_stack_rest_type = 8'h04;
   localparam logic [7:0] enclave_control_page_type = 8'h05;
   localparam logic [63:0] VA_SLOT_MASK = 64'h0000_0000_0000_0007;
   localparam logic [63:0] PAGE_OFFSET_MASK = 64'h0000_0000_0000_0FFF;
   localparam logic [63:0] ALL_ONES = 64'hFFFF_FFFF_FFFF_FFFF;

   // -------------------------------------------------------------
   // Register byte addresses
   // -------------------------------------------------------------
   localparam logic [7:0] REG_LEAF = 8'h00;
   localparam logic [7:0] REG_ADDR_LO = 8'h04;
   localparam logic [7:0] REG_ADDR_HI = 8'h08;
   localparam logic [7:0] REG_CTRL = 8'h0C;
   localparam logic [7:0] REG_DATA_LO = 8'h10;
   localparam logic [7:0] REG_DATA_HI = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_FLAGS = 8'h1C;
   localparam logic [7:0] REG_IRQ_STATUS = 8'h20;
   localparam logic [7:0] REG_IRQ_ENABLE = 8'h24;
   localparam logic [7:0] REG_IRQ_CLEAR = 8'h28;

   // -------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_LMA = 1;
   localparam int CTRL_CSL = 2;
   localparam int FLAG_ZF = 0;
   localparam int FLAG_CF = 1;
   localparam int FLAG_PF = 2;
   localparam int FLAG_AF = 3;
   localparam int FLAG_OF = 4;
   localparam int FLAG_SF = 5;
   localparam int FLAG_BUSY = 8;
   localparam int FLAG_GP = 9;
   localparam int FLAG_PFLT = 10;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_NDBG = 1;
   localparam int IRQ_GP = 2;
   localparam int IRQ_PF = 3;
   localparam int IRQ_BITS = 4;

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_LOOKUP = 1'b1
   } edr_state_t;

endpackage

// ===== verif/edr_map_model.sv
// Page map, segment unit and cache memory answering one lookup per start.
// Assumes the bench loads the answer bundle and delay before each start.
`timescale 1ns/100ps
module edr_map_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // Lookup handshake and answers
   input wire logic lookup_req,
   input wire logic [1:0] dly,
   input wire logic [78:0] ans,
   output logic lookup_ack,
   output logic [78:0] ans_out
);
   logic [1:0] cnt;

   // Answers are inverted outside the ack cycle, so a design that samples
   // them at the wrong moment sees garbage instead of a lucky match
   assign ans_out = lookup_ack ? ans : ~ans;

   always @(posedge clk_sys) begin
      if (reset) begin
         cnt <= 2'h0;
         lookup_ack <= 1'b0;
      end else begin
         lookup_ack <= 1'b0;
         if (lookup_req && !lookup_ack) begin
            if (cnt == dly) begin
               lookup_ack <= 1'b1;
               cnt <= 2'h0;
            end else begin
               cnt <= cnt + 2'h1;
            end
         end
      end
   end
endmodule

// ===== verif/tb.sv
// Self-checking bench of the debug read leaf block.
// Assumes the map model answers lookups; the register port is driven here.
`timescale 1ns/100ps
module tb;
   localparam logic [11:0] TCS_LIM = 12'h100;
   localparam logic [31:0] ND_CODE = 32'h0000_0002;
   localparam logic [63:0] A0 = 64'h0000_1234_5678_9008;
   localparam logic [78:0] OKA = {4'h5, 8'h00, 3'h1, 64'hA5C3_0F1E_9B7D_2468};
   logic clk_sys, reset, reg_write, reg_read, lookup_ack, lookup_req;
   logic gp_fault, page_fault, irq;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, seed, rdv, r1, r2, r3, exp_status;
   logic [63:0] lookup_addr, fault_addr, exp_data, ra;
   logic [78:0] ans, ao;
   logic [1:0] dly;
   logic [5:0] exp_flags;
   int n_fail, total_checks;

   edr_debug_read #(.TCS_LIMIT(TCS_LIM), .NOT_DEBUGGABLE_CODE(ND_CODE))
   i_edr_debug_read (.clk_sys(clk_sys), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .lookup_req(lookup_req),
      .lookup_addr(lookup_addr), .lookup_ack(lookup_ack),
      .seg_fault(ao[78]), .in_cache(ao[77]), .entry_conflict(ao[76]),
      .entry_valid(ao[75]), .entry_type(ao[74:67]),
      .entry_pending(ao[66]), .entry_modified(ao[65]),
      .owner_debug(ao[64]), .mem_data(ao[63:0]), .gp_fault(gp_fault),
      .page_fault(page_fault), .fault_addr(fault_addr), .irq(irq));

   edr_map_model i_edr_map_model (.clk_sys(clk_sys), .reset(reset),
      .lookup_req(lookup_req), .dly(dly), .ans(ans),
      .lookup_ack(lookup_ack), .ans_out(ao));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ----------------------------------------------------------------
   // Checking, bus cycles and expectations
   // ----------------------------------------------------------------
   task chk(input logic [63:0] seen, input logic [63:0] exp, input string m);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: %s seen %h want %h", $time, m,
            seen, exp);
      end
   endtask

   task wrap_up;
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk_sys);
      reg_read <= 1'b0;
      #1 d = reg_rdata;
   endtask

   function automatic logic [31:0] rnd();
      for (int i = 0; i < 32; i++) begin
         seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      end
      return seed;
   endfunction

   function automatic logic [78:0] ty(input logic [78:0] x,
         input logic [7:0] t);
      x[74:67] = t;
      return x;
   endfunction

   // Outcome code doubles as the interrupt status bit index
   function automatic logic [1:0] outcome(input logic [63:0] a,
         input logic w, input logic [78:0] n);
      if (w && a[63:47] != {17{a[47]}}) return 2'h2;
      if (w ? a[2:0] != 3'h0 : a[1:0] != 2'h0) return 2'h2;
      if (n[78]) return 2'h2;
      if (!n[77]) return 2'h3;
      if (n[76]) return 2'h2;
      if (!n[75]) return 2'h3;
      if (n[74:67] > 8'h04) return 2'h3;
      if (n[66] || n[65]) return 2'h1;
      if (n[74:67] == 8'h01 && a[11:0] >= TCS_LIM) return 2'h2;
      if (n[74:67] < 8'h02 && !n[64]) return 2'h2;
      return 2'h0;
   endfunction

   task automatic run(input logic [63:0] a, input logic lma, input logic csl,
         input logic [78:0] an, input logic [3:0] en);
      logic w, seen, gp, pf;
      logic [1:0] k;
      logic [63:0] v;
      logic [31:0] d;
      int i;
      w = lma & csl;
      k = outcome(a, w, an);
      seen = 1'b0;
      gp = 1'b0;
      pf = 1'b0;
      ans <= an;
      dly <= an[1:0];
      wr(edr_pkg::REG_IRQ_ENABLE, {28'h0, en});
      wr(edr_pkg::REG_ADDR_LO, a[31:0]);
      wr(edr_pkg::REG_ADDR_HI, a[63:32]);
      wr(edr_pkg::REG_CTRL, {29'h0, csl, lma, 1'b1});
      for (i = 0; i < 20; i++) begin
         #1;
         seen |= lookup_req;
         if (lookup_req) chk(lookup_addr, a, "lookup address");
         gp |= gp_fault;
         pf |= page_fault;
         if (gp || pf || (seen && !lookup_req)) break;
         @(posedge clk_sys);
      end
      chk(64'(i < 20), 64'h1, "leaf finished");
      chk(64'(gp), 64'(k == 2'h2), "protection fault");
      chk(64'(pf), 64'(k == 2'h3), "page fault");
      if (pf) chk(fault_addr, a, "fault address");
      if (k == 2'h0) begin
         v = an[63:0];
         // Every type past thread control returns the slot indicator
         if (an[74:67] >= 8'h02) v = (v & ~64'h7) != 64'h0 ? '1 : 64'h0;
         if (w) exp_data = v;
         else exp_data[31:0] = v[31:0];
         exp_status = 32'h0;
         exp_flags = 6'h00;
      end else if (k == 2'h1) begin
         exp_status = ND_CODE;
         exp_flags = 6'h01;
      end
      rd(edr_pkg::REG_STATUS, d);
      chk(64'(d), 64'(exp_status), "status");
      rd(edr_pkg::REG_FLAGS, d);
      chk(64'(d), 64'({k == 2'h3, k == 2'h2, 3'h0, exp_flags}),
         "flags");
      rd(edr_pkg::REG_DATA_LO, d);
      chk(64'(d), 64'(exp_data[31:0]), "data low");
      rd(edr_pkg::REG_DATA_HI, d);
      chk(64'(d), 64'(exp_data[63:32]), "data high");
      rd(edr_pkg::REG_IRQ_STATUS, d);
      chk(64'(d), 64'h1 << k, "event bit");
      chk(64'(irq), 64'(en[k]), "interrupt level");
      wr(edr_pkg::REG_IRQ_CLEAR, 32'hF);
      rd(edr_pkg::REG_IRQ_STATUS, d);
      chk(64'({irq, d}), 64'h0, "interrupt cleared");
      $display("Test done: address %h outcome %0d", a, k);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      ans = OKA;
      dly = 2'h0;
      seed = 32'h0001_8385;
      exp_data = 64'h0;
      exp_status = 32'h0;
      exp_flags = 6'h00;
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      for (int j = 0; j < 12; j++) begin
         rd(8'(j * 4), rdv);
         chk(64'(rdv), 64'h0, "reset or unmapped value");
      end
      // Leaf register still 0: a start must do nothing
      wr(edr_pkg::REG_CTRL, 32'h7);
      rd(edr_pkg::REG_IRQ_STATUS, rdv);
      chk(64'({lookup_req, rdv}), 64'h0, "other leaf ignored");
      wr(edr_pkg::REG_LEAF, 32'h4);
      run(A0, 1'b1, 1'b1, OKA, 4'hF);
      run(A0 | 64'h4, 1'b1, 1'b0, OKA, 4'h0);
      run(A0 | 64'h4, 1'b1, 1'b1, OKA, 4'hF);
      run(A0 | 64'h2, 1'b0, 1'b1, OKA, 4'hF);
      run(A0 ^ 64'h8000_0000_0000_0000, 1'b1, 1'b1, OKA, 4'hF);
      run(A0 ^ 64'h8000_0000_0000_0000, 1'b0, 1'b0, OKA, 4'hF);
      for (int j = 64; j < 79; j++) begin
         run(A0, 1'b1, 1'b1, OKA ^ (79'h1 << j), 4'hF);
      end
      for (int t = 0; t < 7; t++) begin
         run(A0, 1'b1, 1'b1, ty(OKA ^ 79'h1 << 64, 8'(t)), 4'hF);
      end
      run({A0[63:12], 12'h100}, 1'b0, 1'b0, ty(OKA, 8'h01), 4'hF);
      run({A0[63:12], 12'h0FC}, 1'b0, 1'b0, ty(OKA, 8'h01), 4'hF);
      run(A0, 1'b1, 1'b1, ty({OKA[78:64], 64'h7}, 8'h02), 4'hF);
      run(A0, 1'b0, 1'b1, ty(OKA, 8'h02), 4'hF);
      run(A0, 1'b1, 1'b1, OKA ^ (79'h3 << 77), 4'hF);
      run(A0, 1'b1, 1'b1, OKA ^ (79'h1 << 75) ^ (79'h1 << 66), 4'hF);
      for (int j = 0; j < 60; j++) begin
         r1 = rnd();
         r2 = rnd();
         r3 = rnd();
         ra = {{17{r1[30]}}, r1[14:0], r2};
         if (r1[20:18] != 3'h0) ra[2:0] = 3'h0;
         if (r1[23:21] == 3'h0) ra[63] = ~ra[63];
         run(ra, r3[24], r3[25] | r3[26], {r3[2:0] == 3'h0,
            r3[5:3] != 3'h0, r3[8:6] == 3'h0, r3[11:9] != 3'h0, 5'h0,
            r3[14:12], r3[17:15] == 3'h0, r3[20:18] == 3'h0,
            r3[23:21] != 3'h0, r1, r2}, {4{r3[27]}});
      end
      wrap_up();
   end

   // Runs take about 25 cycles each; this span leaves wide margin
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_fail++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      wrap_up();
   end
endmodule
